// ===== core/pfsw_pkg.sv
`default_nettype none
package pfsw_pkg;

    // ==========================================================
    // register offsets
    localparam logic [2:0] OFS_CTRL_STATUS = 3'h0;
    localparam logic [2:0] OFS_UNLOCK_KEY  = 3'h1;
    localparam logic [2:0] OFS_DATA_LOW    = 3'h2;
    localparam logic [2:0] OFS_DATA_HIGH   = 3'h3;
    localparam logic [2:0] OFS_ADDR_LOW    = 3'h4;
    localparam logic [2:0] OFS_ADDR_HIGH   = 3'h5;

    // ==========================================================
    // control/status fields
    localparam int BIT_SPACE  = 6;
    localparam int BIT_LATCH  = 5;
    localparam int BIT_ERASE  = 4;
    localparam int BIT_ENABLE = 2;
    localparam int BIT_WRITE  = 1;
    localparam int BIT_READ   = 0;
    localparam logic [7:0] CTRL_RESET   = 8'h80;
    localparam logic [7:0] KEY_FIRST    = 8'h55;
    localparam logic [7:0] KEY_SECOND   = 8'haa;
    localparam logic [5:0] ADDR_HI_MASK = 6'h1f;

    // ==========================================================
    // geometry and timing
    localparam int WORD_W      = 14;
    localparam int ADDR_W      = 13;
    localparam int ROW_BITS    = 5;
    localparam int SETUP_CYC   = 2;
    localparam int PWRT_MS     = 64;
    localparam int CLK_MHZ     = 250;
    localparam int PWRT_CYC    = PWRT_MS * 1000 * CLK_MHZ;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_LATCH  = 3'b010,
        ST_BUSY   = 3'b011,
        ST_READ   = 3'b100,
        ST_DONE   = 3'b101
    } pfsw_state_e;

    typedef struct packed
    {
        logic                space;
        logic [ADDR_W-1:0]   addr;
    } pfsw_loc_s;

    typedef struct packed
    {
        logic                erase;
        logic                prog;
        logic                load;
        logic                read;
        pfsw_loc_s           loc;
        logic [WORD_W-1:0]   data;
    } pfsw_req_s;

endpackage
`default_nettype wire

// ===== core/pfsw_row_latch.sv
`timescale 1ns/100ps
`default_nettype none
module pfsw_row_latch #(
    parameter int WIDTH = 14,
    parameter int ROWS  = 32
) (
    input  wire logic                     clk,
    input  wire logic                     program_erase_enable,
    input  wire logic [$clog2(ROWS)-1:0]  wrIdx,
    input  wire logic [WIDTH-1:0]         wrData,
    input  wire logic [$clog2(ROWS)-1:0]  rdIdx,
    output logic      [WIDTH-1:0]         rdData
);
    // ==========================================================
    // row write latches, registered read
    logic [WIDTH-1:0] mem [ROWS];

    always_ff @(posedge clk)
    begin
        if (program_erase_enable)
        begin
            mem[wrIdx] <= wrData;
        end
        rdData <= mem[rdIdx];
    end
endmodule
`default_nettype wire

// ===== core/pfsw_ctrl.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pfsw_ctrl #(
    parameter int PWRT_CYCLES = pfsw_pkg::PWRT_CYC,
    parameter int ROW_WORDS   = 32
) (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire logic [2:0]                       regAddr,
    input  wire logic [7:0]                       regWrData,
    input  wire logic                             regWr,
    input  wire logic                             regRd,
    output logic      [7:0]                       regRdData,
    input  wire logic                             serialProgReq,
    input  wire logic                             protectActive,
    output logic                                  serialProgDeny,
    output logic                                  fetchStall,
    output logic                                  forceNop,
    output pfsw_pkg::pfsw_req_s                   flashReq,
    output logic      [pfsw_pkg::WORD_W-1:0]      flashLatchWord,
    input  wire logic                             flashDone,
    input  wire logic [pfsw_pkg::WORD_W-1:0]      flashRdData
);
    localparam int IDX_W = $clog2(ROW_WORDS);
    localparam int PW_W  = $clog2(PWRT_CYCLES + 1);

    // ==========================================================
    // helpers
    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
        hit = (a == ofs);
    endfunction

    // ==========================================================
    // registers
    logic                        spaceSel, latchOnly, eraseSel, progEnable, writeCmd, readCmd;
    logic [7:0]                  addrLow;
    logic [4:0]                  addrHigh;
    logic [7:0]                  dataLow;
    logic [5:0]                  dataHigh;
    logic [1:0]                  keyStage;
    logic [PW_W-1:0]             pwrtCnt;
    logic [1:0]                  setupCnt;
    logic                        opErase, opProgram;
    logic [IDX_W-1:0]            progIdx;
    pfsw_pkg::pfsw_state_e       state, next_state;
    logic                        serSync1, serSync2;

    // ==========================================================
    // decode
    wire wrCtrl  = regWr && hit(regAddr, pfsw_pkg::OFS_CTRL_STATUS);
    wire wrKey   = regWr && hit(regAddr, pfsw_pkg::OFS_UNLOCK_KEY);
    wire wrDatL  = regWr && hit(regAddr, pfsw_pkg::OFS_DATA_LOW);
    wire wrDatH  = regWr && hit(regAddr, pfsw_pkg::OFS_DATA_HIGH);
    wire wrAdrL  = regWr && hit(regAddr, pfsw_pkg::OFS_ADDR_LOW);
    wire wrAdrH  = regWr && hit(regAddr, pfsw_pkg::OFS_ADDR_HIGH);
    wire idle    = (state == pfsw_pkg::ST_IDLE);
    wire pwrtRun = (pwrtCnt != '0);
    wire unlocked = (keyStage == 2'h2);
    wire setWr   = wrCtrl && regWrData[pfsw_pkg::BIT_WRITE] && idle;
    wire setRd   = wrCtrl && regWrData[pfsw_pkg::BIT_READ] && idle && !setWr;
    // modification needs enable, key and elapsed power-up timer
    wire startWr = setWr && progEnable && unlocked && !pwrtRun;
    wire [pfsw_pkg::ADDR_W-1:0] wordAddr = {addrHigh, addrLow};
    wire [pfsw_pkg::ADDR_W-1:0] rowAddr  =
        {wordAddr[pfsw_pkg::ADDR_W-1:pfsw_pkg::ROW_BITS], {pfsw_pkg::ROW_BITS{1'b0}}};
    wire [IDX_W-1:0] latchIdx = addrLow[IDX_W-1:0];
    wire latchWe = (state == pfsw_pkg::ST_LATCH);
    wire [7:0] ctrlView = pfsw_pkg::CTRL_RESET | {1'b0, spaceSel, latchOnly, eraseSel, 1'b0,
                                                   progEnable, writeCmd, readCmd};
    wire [7:0] rdMux =
        hit(regAddr, pfsw_pkg::OFS_CTRL_STATUS) ? ctrlView :
        hit(regAddr, pfsw_pkg::OFS_DATA_LOW)    ? dataLow :
        hit(regAddr, pfsw_pkg::OFS_DATA_HIGH)   ? {2'h0, dataHigh} :
        hit(regAddr, pfsw_pkg::OFS_ADDR_LOW)    ? addrLow :
        hit(regAddr, pfsw_pkg::OFS_ADDR_HIGH)   ? {3'h0, addrHigh} :
        8'h00;
    wire lastProg = (progIdx == IDX_W'(ROW_WORDS - 1));
    wire [pfsw_pkg::ADDR_W-1:0] progOfs = {{(pfsw_pkg::ADDR_W - IDX_W){1'b0}}, progIdx};

    // ==========================================================
    // row latch memory
    pfsw_row_latch #(
        .WIDTH (pfsw_pkg::WORD_W),
        .ROWS  (ROW_WORDS)
    ) u_latch (
        .clk    (clk),
        .program_erase_enable   (latchWe),
        .wrIdx  (latchIdx),
        .wrData ({dataHigh, dataLow}),
        .rdIdx  (progIdx),
        .rdData (flashLatchWord)
    );

    // ==========================================================
    // sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            pfsw_pkg::ST_IDLE:
                if (startWr || setRd)
                    next_state = pfsw_pkg::ST_SETUP;
            pfsw_pkg::ST_SETUP:
                if (setupCnt == 2'(pfsw_pkg::SETUP_CYC - 1))
                    next_state = readCmd ? pfsw_pkg::ST_READ :
                                 opErase ? pfsw_pkg::ST_BUSY : pfsw_pkg::ST_LATCH;
            pfsw_pkg::ST_LATCH:
                next_state = opProgram ? pfsw_pkg::ST_BUSY : pfsw_pkg::ST_DONE;
            pfsw_pkg::ST_BUSY:
                if (flashDone && (opErase || lastProg))
                    next_state = pfsw_pkg::ST_DONE;
            pfsw_pkg::ST_READ:
                if (flashDone)
                    next_state = pfsw_pkg::ST_DONE;
            pfsw_pkg::ST_DONE:
                next_state = pfsw_pkg::ST_IDLE;
            default:
                next_state = pfsw_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= pfsw_pkg::ST_IDLE;
            setupCnt <= 2'h0;
            progIdx  <= '0;
        end
        else
        begin
            state    <= next_state;
            setupCnt <= (state == pfsw_pkg::ST_SETUP) ? setupCnt + 2'h1 : 2'h0;
            if (state == pfsw_pkg::ST_BUSY && flashDone && !opErase)
                progIdx <= progIdx + 1'b1;
            else if (state != pfsw_pkg::ST_BUSY)
                progIdx <= '0;
        end
    end

    // ==========================================================
    // control/status register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spaceSel   <= 1'b0;
            latchOnly  <= 1'b0;
            eraseSel   <= 1'b0;
            progEnable <= 1'b0;
            writeCmd   <= 1'b0;
            readCmd    <= 1'b0;
            opErase    <= 1'b0;
            opProgram  <= 1'b0;
        end
        else
        begin
            if (wrCtrl && idle)
            begin
                spaceSel   <= regWrData[pfsw_pkg::BIT_SPACE];
                latchOnly  <= regWrData[pfsw_pkg::BIT_LATCH];
                progEnable <= regWrData[pfsw_pkg::BIT_ENABLE];
            end
            // erase bit: set by software, cleared by hardware after erase
            if (state == pfsw_pkg::ST_DONE && opErase)
                eraseSel <= 1'b0;
            else if (wrCtrl && idle)
                eraseSel <= regWrData[pfsw_pkg::BIT_ERASE];
            if (startWr)
            begin
                writeCmd  <= 1'b1;
                opErase   <= eraseSel;
                opProgram <= !eraseSel && !latchOnly;
            end
            else if (state == pfsw_pkg::ST_DONE)
            begin
                writeCmd  <= 1'b0;
                // stale op kind would misroute later reads and erase clears
                opErase   <= 1'b0;
                opProgram <= 1'b0;
            end
            if (setRd)
                readCmd <= 1'b1;
            else if (state == pfsw_pkg::ST_DONE)
                readCmd <= 1'b0;
        end
    end

    // ==========================================================
    // address, data, key, power-up timer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addrLow  <= 8'h00;
            addrHigh <= 5'h00;
            dataLow  <= 8'h00;
            dataHigh <= 6'h00;
            keyStage <= 2'h0;
            pwrtCnt  <= PW_W'(PWRT_CYCLES);
        end
        else
        begin
            if (pwrtRun)
                pwrtCnt <= pwrtCnt - 1'b1;
            if (wrAdrL)
                addrLow <= regWrData;
            if (wrAdrH)
                addrHigh <= regWrData[4:0];
            if (state == pfsw_pkg::ST_READ && flashDone)
            begin
                dataHigh <= flashRdData[13:8];
                dataLow  <= flashRdData[7:0];
            end
            else
            begin
                if (wrDatL)
                    dataLow <= regWrData;
                if (wrDatH)
                    dataHigh <= regWrData[5:0];
            end
            // key: any other access between steps breaks the sequence
            if (wrKey && regWrData == pfsw_pkg::KEY_FIRST)
                keyStage <= 2'h1;
            else if (wrKey && regWrData == pfsw_pkg::KEY_SECOND && keyStage == 2'h1)
                keyStage <= 2'h2;
            else if (regWr || regRd)
                keyStage <= 2'h0;
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdData      <= 8'h00;
            fetchStall     <= 1'b0;
            forceNop       <= 1'b0;
            flashReq       <= '0;
            serSync1       <= 1'b0;
            serSync2       <= 1'b0;
            serialProgDeny <= 1'b0;
        end
        else
        begin
            regRdData  <= regRd ? rdMux : 8'h00;
            // reads and fetch never blocked by protection
            forceNop   <= (next_state == pfsw_pkg::ST_SETUP);
            fetchStall <= writeCmd && !(state == pfsw_pkg::ST_DONE);
            flashReq.erase      <= (next_state == pfsw_pkg::ST_BUSY) && opErase;
            flashReq.prog       <= (next_state == pfsw_pkg::ST_BUSY) && !opErase;
            flashReq.load       <= latchWe;
            flashReq.read       <= (next_state == pfsw_pkg::ST_READ);
            flashReq.loc.space  <= spaceSel;
            flashReq.loc.addr   <= (opErase || opProgram) ? (rowAddr | progOfs)
                                                          : wordAddr;
            flashReq.data       <= {dataHigh, dataLow};
            serSync1       <= serialProgReq;
            serSync2       <= serSync1;
            serialProgDeny <= serSync2 && protectActive;
        end
    end

    // ==========================================================
    // checks
    property p_no_mod_disabled;
        @(posedge clk) disable iff (!rst_n)
        (setWr && !progEnable) |=> !writeCmd;
    endproperty
    a_no_mod_disabled: assert property (p_no_mod_disabled) else $error("write without enable");

    sequence s_key;
        wrKey && regWrData == pfsw_pkg::KEY_FIRST ##1 wrKey && regWrData == pfsw_pkg::KEY_SECOND;
    endsequence
    property p_key_needed;
        @(posedge clk) disable iff (!rst_n)
        (setWr && keyStage != 2'h2) |=> !writeCmd;
    endproperty
    a_key_needed: assert property (p_key_needed) else $error("write without key");

    property p_wr_sticky;
        @(posedge clk) disable iff (!rst_n)
        (writeCmd && state != pfsw_pkg::ST_DONE) |=> writeCmd;
    endproperty
    a_wr_sticky: assert property (p_wr_sticky) else $error("write bit lost early");

    property p_setup_nop;
        @(posedge clk) disable iff (!rst_n)
        $rose(writeCmd) |-> forceNop ##1 forceNop;
    endproperty
    a_setup_nop: assert property (p_setup_nop) else $error("setup not forced");

    property p_erase_clear;
        @(posedge clk) disable iff (!rst_n)
        (state == pfsw_pkg::ST_DONE && opErase) |=> !eraseSel && !writeCmd;
    endproperty
    a_erase_clear: assert property (p_erase_clear) else $error("erase bit not cleared");

    property p_read_data;
        @(posedge clk) disable iff (!rst_n)
        (state == pfsw_pkg::ST_READ && flashDone) |=> {dataHigh, dataLow} == $past(flashRdData);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    property p_latch_only;
        @(posedge clk) disable iff (!rst_n)
        (state == pfsw_pkg::ST_LATCH && !opProgram) |=> state == pfsw_pkg::ST_DONE;
    endproperty
    a_latch_only: assert property (p_latch_only) else $error("latch-only programmed");

    property p_pwrt;
        @(posedge clk) disable iff (!rst_n)
        pwrtRun |-> !startWr;
    endproperty
    a_pwrt: assert property (p_pwrt) else $error("write during power-up");

    property p_key_seq;
        @(posedge clk) disable iff (!rst_n)
        s_key |=> keyStage == 2'h2;
    endproperty
    a_key_seq: assert property (p_key_seq) else $error("key not recognised");
endmodule
`default_nettype wire

// ===== verif/pfsw_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module pfsw_flash_model (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire pfsw_pkg::pfsw_req_s  flashReq,
    input  wire logic [13:0]          flashLatchWord,
    input  wire logic [7:0]           lat,
    output logic                      flashDone,
    output logic      [13:0]          flashRdData
);
    // ==========================================================
    // flash array: one word per read or program answer, a whole 32-word row per erase; latency set by the bench
    logic [13:0] mem [0:16383];
    int          cnt;
    int          cool;
    int          progCount  = 0;
    int          eraseCount = 0;
    wire         active = flashReq.read | flashReq.prog | flashReq.erase;
    wire  [13:0] idx    = {flashReq.loc.space, flashReq.loc.addr};
    initial
    begin
        for (int i = 0; i < 16384; i++)
            mem[i] = 14'h3fff;
    end
    // cool-down so a request still standing after its answer is not served twice
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt = 0;
            cool = 0;
            flashDone <= 1'b0;
            flashRdData <= 14'h0000;
        end
        else
        begin
            flashDone <= 1'b0;
            // read data only valid with the answer; toggles otherwise
            flashRdData <= ~flashRdData;
            if (cool > 0)
                cool--;
            else if (active && cnt < int'(lat))
                cnt++;
            else if (active)
            begin
                cnt = 0;
                cool = 2;
                flashDone <= 1'b1;
                if (flashReq.read)
                    flashRdData <= mem[idx];
                if (flashReq.prog)
                    mem[idx] = flashLatchWord;
                if (flashReq.prog)
                    progCount++;
                if (flashReq.erase)
                    eraseCount++;
                if (flashReq.erase)
                    for (int i = 0; i < 32; i++)
                        mem[{idx[13:5], 5'(i)}] = 14'h3fff;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb;
    // ==========================================================
    // wiring
    logic                clk           = 1'b0;
    logic                rst_n         = 1'b0;
    logic [2:0]          regAddr       = 3'h0;
    logic [7:0]          regWrData     = 8'h00;
    logic                regWr         = 1'b0;
    logic                regRd         = 1'b0;
    logic                serialProgReq = 1'b0;
    logic                protectActive = 1'b0;
    logic [7:0]          modelLat      = 8'h01;
    logic [7:0]          regRdData;
    logic                serialProgDeny;
    logic                fetchStall;
    logic                forceNop;
    logic                flashDone;
    pfsw_pkg::pfsw_req_s flashReq;
    logic [13:0]         flashLatchWord;
    logic [13:0]         flashRdData;
    integer              seed          = 32'h9ee5172e;
    int                  bad_count     = 0;
    int                  check_count   = 0;
    logic [7:0]          expQ[$];
    logic [7:0]          mskQ[$];
    string               nameQ[$];
    logic                rdPend        = 1'b0;
    logic [7:0]          lastRd;
    logic [7:0]          e;
    logic [7:0]          m;
    string               n;
    logic [13:0]         word [0:31];
    logic [13:0]         w1;
    logic [12:0]         base;
    int                  nopRun        = 0;
    always #2 clk = ~clk;
    // short power-up timer keeps the run brief
    pfsw_ctrl #(.PWRT_CYCLES(10), .ROW_WORDS(32)) i_pfsw_ctrl (.clk(clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .serialProgReq(serialProgReq), .protectActive(protectActive),
        .serialProgDeny(serialProgDeny), .fetchStall(fetchStall), .forceNop(forceNop),
        .flashReq(flashReq), .flashLatchWord(flashLatchWord), .flashDone(flashDone),
        .flashRdData(flashRdData));
    pfsw_flash_model i_pfsw_flash_model (.clk(clk), .rst_n(rst_n), .flashReq(flashReq),
        .flashLatchWord(flashLatchWord), .lat(modelLat), .flashDone(flashDone),
        .flashRdData(flashRdData));
    // ==========================================================
    // result watcher: read data stands one cycle after the strobe
    always @(negedge clk)
    begin
        if (rdPend && mskQ.size() > 0)
        begin
            n = nameQ.pop_front();
            e = expQ.pop_front();
            m = mskQ.pop_front();
            lastRd = regRdData;
            if (m != 8'h00) `CHK(n, e & m, regRdData & m)
        end
        rdPend = regRd;
        if (flashDone && (flashReq.prog || flashReq.erase)) `CHK("stall", 1'b1, fetchStall)
        // every launch must force exactly the setup cycles to no-op
        if (forceNop)
            nopRun++;
        else if (nopRun != 0)
        begin
            `CHK("nop run", pfsw_pkg::SETUP_CYC, nopRun)
            nopRun = 0;
        end
    end
    // ==========================================================
    // bus tasks
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWrData <= d;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] ex, input logic [7:0] mk, string nm);
        bus(1'b0, 1'b1, a, 8'h00);
        expQ.push_back(ex);
        mskQ.push_back(mk);
        nameQ.push_back(nm);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic poll(input int b);
        int i;
        for (i = 0; i < 3000; i++)
        begin
            rd(pfsw_pkg::OFS_CTRL_STATUS, 8'h00, 8'h00, "poll");
            bus(1'b0, 1'b0, 3'h0, 8'h00);
            @(negedge clk);
            #1;
            if (lastRd[b] === 1'b0)
                break;
        end
        if (i == 3000)
        begin
            bad_count++;
            $display("FAIL poll exp 0 got 1");
            test_done();
        end
    endtask
    task automatic unlock(input logic [7:0] c, input logic [7:0] k1, input logic [7:0] k2);
        wr(pfsw_pkg::OFS_CTRL_STATUS, c);
        wr(pfsw_pkg::OFS_UNLOCK_KEY, k1);
        wr(pfsw_pkg::OFS_UNLOCK_KEY, k2);
        wr(pfsw_pkg::OFS_CTRL_STATUS, c | 8'h02);
    endtask
    task automatic launch(input logic [7:0] c);
        unlock(c, pfsw_pkg::KEY_FIRST, pfsw_pkg::KEY_SECOND);
        bus(1'b0, 1'b0, 3'h0, 8'h00);
        poll(1);
    endtask
    task automatic readWord(input logic [7:0] lo, input logic [7:0] c, input logic [13:0] x);
        wr(pfsw_pkg::OFS_ADDR_LOW, lo);
        wr(pfsw_pkg::OFS_CTRL_STATUS, c);
        poll(0);
        rd(pfsw_pkg::OFS_DATA_LOW, x[7:0], 8'hff, "data low");
        rd(pfsw_pkg::OFS_DATA_HIGH, {2'b00, x[13:8]}, 8'hff, "data high");
        bus(1'b0, 1'b0, 3'h0, 8'h00);
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(pfsw_pkg::OFS_CTRL_STATUS, pfsw_pkg::CTRL_RESET, 8'hff, "ctrl reset");
        unlock(8'h04, pfsw_pkg::KEY_FIRST, pfsw_pkg::KEY_SECOND);
        rd(pfsw_pkg::OFS_CTRL_STATUS, 8'h00, 8'h02, "timer block");
        rd(pfsw_pkg::OFS_UNLOCK_KEY, 8'h00, 8'hff, "key");
        rd(3'h6, 8'h00, 8'hff, "unmapped");
        bus(1'b0, 1'b0, 3'h0, 8'h00);
        repeat (12) @(posedge clk);
        unlock(8'h00, pfsw_pkg::KEY_FIRST, pfsw_pkg::KEY_SECOND);
        rd(pfsw_pkg::OFS_CTRL_STATUS, 8'h00, 8'h02, "no enable");
        unlock(8'h04, pfsw_pkg::KEY_SECOND, pfsw_pkg::KEY_FIRST);
        rd(pfsw_pkg::OFS_CTRL_STATUS, 8'h00, 8'h02, "key order");
        wr(pfsw_pkg::OFS_UNLOCK_KEY, pfsw_pkg::KEY_FIRST);
        rd(pfsw_pkg::OFS_DATA_LOW, 8'h00, 8'h00, "gap");
        wr(pfsw_pkg::OFS_UNLOCK_KEY, pfsw_pkg::KEY_SECOND);
        wr(pfsw_pkg::OFS_CTRL_STATUS, 8'h06);
        rd(pfsw_pkg::OFS_CTRL_STATUS, 8'h00, 8'h02, "key broken");
        bus(1'b0, 1'b0, 3'h0, 8'h00);
        repeat (40) @(posedge clk);
        `CHK("no op", 0, i_pfsw_flash_model.progCount + i_pfsw_flash_model.eraseCount)
        $display("test refusals done");
        serialProgReq <= 1'b1;
        protectActive <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("deny", 1'b1, serialProgDeny)
        serialProgReq <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("deny off", 1'b0, serialProgDeny)
        $display("test serial done");
        // self-write stays possible while protected
        base = 13'($random(seed)) & 13'h1fe0;
        wr(pfsw_pkg::OFS_ADDR_HIGH, {3'h0, base[12:8]});
        for (int i = 0; i < 32; i++)
        begin
            word[i] = 14'($random(seed));
            modelLat <= 8'(1 + {$random(seed)} % 12);
            wr(pfsw_pkg::OFS_ADDR_LOW, {base[7:5], 5'(i)});
            wr(pfsw_pkg::OFS_DATA_LOW, word[i][7:0]);
            wr(pfsw_pkg::OFS_DATA_HIGH, {2'b00, word[i][13:8]});
            launch(i == 31 ? 8'h04 : 8'h24);
            if (i == 30) `CHK("latch only", 0, i_pfsw_flash_model.progCount)
        end
        `CHK("row words", 32, i_pfsw_flash_model.progCount)
        for (int i = 0; i < 32; i++)
            readWord({base[7:5], 5'(i)}, 8'h01, word[i]);
        $display("test row write done");
        w1 = 14'($random(seed));
        i_pfsw_flash_model.mem[{1'b1, base}] = w1;
        readWord(base[7:0], 8'h41, w1);
        readWord(base[7:0], 8'h01, word[0]);
        $display("test space done");
        wr(pfsw_pkg::OFS_ADDR_LOW, base[7:0] | 8'h0b);
        launch(8'h14);
        rd(pfsw_pkg::OFS_CTRL_STATUS, 8'h00, 8'h12, "erase clear");
        readWord(base[7:0] | 8'h03, 8'h01, 14'h3fff);
        `CHK("erase count", 1, i_pfsw_flash_model.eraseCount)
        `CHK("row words", 32, i_pfsw_flash_model.progCount)
        $display("test erase done");
        test_done();
    end
endmodule
`default_nettype wire
